// >>> src/aurf_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and types of the unlock and relay framer.
// ---------------------------------------------------------------------------
package aurf_pkg;

	// Frame delimiter, type codes and checksum base.
	localparam logic [7:0]  AURF_DELIM          = 8'h7E;
	localparam logic [7:0]  AURF_TYPE_UNLK_REQ  = 8'h2C;
	localparam logic [7:0]  AURF_TYPE_UNLK_RSP  = 8'hAC;
	localparam logic [7:0]  AURF_TYPE_RELAY_IN  = 8'h2D;
	localparam logic [7:0]  AURF_TYPE_RELAY_OUT = 8'hAD;
	localparam logic [7:0]  AURF_TYPE_TX_STATUS = 8'h89;
	localparam logic [7:0]  AURF_CKS_BASE       = 8'hFF;
	localparam logic [7:0]  AURF_ZERO_BYTE      = 8'h00;

	// Authentication step codes and failure codes.
	localparam logic [7:0]  AURF_STEP_A         = 8'h01;
	localparam logic [7:0]  AURF_STEP_B         = 8'h02;
	localparam logic [7:0]  AURF_STEP_M1        = 8'h03;
	localparam logic [7:0]  AURF_STEP_M2        = 8'h04;
	localparam logic [7:0]  AURF_ERR_CRYPTO     = 8'h80;
	localparam logic [7:0]  AURF_ERR_LENGTH     = 8'h81;
	localparam logic [7:0]  AURF_ERR_PROOF      = 8'h82;
	localparam logic [7:0]  AURF_ERR_SEQUENCE   = 8'h84;

	// Relay destinations and transmit status codes.
	localparam logic [7:0]  AURF_DEST_SERIAL    = 8'h00;
	localparam logic [7:0]  AURF_DEST_BLE       = 8'h01;
	localparam logic [7:0]  AURF_DEST_SCRIPT    = 8'h02;
	localparam logic [7:0]  AURF_ST_BAD_IFACE   = 8'h7C;
	localparam logic [7:0]  AURF_ST_BUSY        = 8'h7D;

	// Byte offsets inside a frame.
	localparam logic [15:0] AURF_OFS_DELIM      = 16'h0000;
	localparam logic [15:0] AURF_OFS_LEN_HI     = 16'h0001;
	localparam logic [15:0] AURF_OFS_LEN_LO     = 16'h0002;
	localparam logic [15:0] AURF_OFS_TYPE       = 16'h0003;
	localparam logic [15:0] AURF_OFS_ID         = 16'h0004;
	localparam logic [15:0] AURF_OFS_DEST       = 16'h0005;
	localparam logic [15:0] AURF_OFS_PAYLOAD    = 16'h0005;
	localparam logic [15:0] AURF_OFS_B          = 16'h0009;
	localparam logic [15:0] AURF_OFS_TX_NONCE   = 16'h0025;
	localparam logic [15:0] AURF_OFS_RX_NONCE   = 16'h0031;
	localparam logic [15:0] AURF_OFS_RELAY_DATA = 16'h0006;

	// Length field values and field sizes.
	localparam logic [15:0] AURF_LEN_STEP_A     = 16'h0082;
	localparam logic [15:0] AURF_LEN_STEP_M1    = 16'h0022;
	localparam logic [15:0] AURF_LEN_RSP_B      = 16'h0086;
	localparam logic [15:0] AURF_LEN_RSP_M2     = 16'h003A;
	localparam logic [15:0] AURF_LEN_RSP_ERR    = 16'h0002;
	localparam logic [15:0] AURF_LEN_STATUS     = 16'h0003;
	localparam logic [15:0] AURF_LEN_RELAY_HDR  = 16'h0003;
	localparam logic [15:0] AURF_LEN_OUT_ADJ    = 16'h0001;
	localparam logic [15:0] AURF_NONCE_BYTES    = 16'h000C;
	localparam logic [15:0] AURF_ONE            = 16'h0001;
	localparam logic [31:0] AURF_CTR_INIT       = 32'h0000_0001;

	// Cipher counter block: fixed nonce prefix and running count.
	typedef struct packed {
		logic [95:0] nonce;
		logic [31:0] count;
	} aurf_ctrblk_t;

	// One relayed byte with its destination and end marker.
	typedef struct packed {
		logic [7:0] data;
		logic [1:0] dest;
		logic       last;
	} aurf_relay_t;

	// One byte of a client value (A or M1) handed to the crypto engine.
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] step;
	} aurf_peer_t;

	typedef enum logic [2:0] {
		AURF_RX_IDLE   = 3'b000,
		AURF_RX_LEN_HI = 3'b001,
		AURF_RX_LEN_LO = 3'b010,
		AURF_RX_BODY   = 3'b011,
		AURF_RX_CKS    = 3'b100
	} aurf_rx_t;

	typedef enum logic [1:0] {
		AURF_K_STATUS = 2'b00,
		AURF_K_UNLOCK = 2'b01,
		AURF_K_RELAY  = 2'b10
	} aurf_kind_t;

endpackage : aurf_pkg

// >>> src/aurf_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Flip-flop FIFO with valid/ready on both sides and a flush.
// ---------------------------------------------------------------------------
module aurf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	import aurf_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wrPtr;
		logic [AW:0]                 rdPtr;
	} aurf_fifo_st_t;

	aurf_fifo_st_t s;
	aurf_fifo_st_t next_s;
	logic          full;
	logic          empty;

	// Full when the pointers differ only in the wrap bit.
	assign full     = (s.wrPtr[AW] != s.rdPtr[AW]) && (s.wrPtr[AW-1:0] == s.rdPtr[AW-1:0]);
	assign empty    = (s.wrPtr == s.rdPtr);
	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = s.mem[s.rdPtr[AW-1:0]];

	// Pointer and storage update; a flush empties the queue at once.
	always_comb begin
		next_s = s;
		if (flush) begin
			next_s.rdPtr = s.wrPtr;
		end else begin
			if (inValid && !full) begin
				next_s.mem[s.wrPtr[AW-1:0]] = inData;
				next_s.wrPtr = s.wrPtr + 1'b1;
			end
			if (outReady && !empty) begin
				next_s.rdPtr = s.rdPtr + 1'b1;
			end
		end
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule : aurf_fifo
`default_nettype wire

// >>> src/aurf_framer.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Unlock handshake and user data relay framer.
// ---------------------------------------------------------------------------
// What this block does
// - A zero A value drops the link instead of answering.
// - Step 2 answer carries 4-byte salt at offset 5, key B at offset 9.
// - Step 4 answer: M2 at 5, transmit nonce at 37, receive nonce at 49.
// - Service counts as unlocked only once the M2 answer is complete.
// - After unlock all content uses AES-256 counter mode with the session key.
// - Counter block is 128 bits: 12-byte nonce prefix, count starting at 1.
// - Inbound data uses the transmit nonce, outbound the receive nonce.
// - Relay frame has type 0x2D at offset 3 and frame id at offset 4.
// - Frame id zero suppresses every response, errors included.
// - Destination byte at 5: 0 serial, 1 BLE, 2 scripting engine.
// - Relay data runs from offset 6 up to the checksum.
// - Checksum is 0xFF minus the low byte of the sum from offset 3.
// - 16-bit length at offset 1 counts bytes between length and checksum.
// - Data for the serial port leaves as a relay output frame, type 0xAD.
// - Unknown destination gives status frame 0x89 with code 0x7C.
// - Destination unable to take data gives status code 0x7D.
// - A successful relay produces no status frame.
// - Unlock requests are type 0x2C, answers 0xAC, step byte at offset 4.
// - Failures answer with step codes 0x80 to 0x84.
module aurf_framer #(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic [7:0]           rxData,
	input  wire logic                 rxValid,
	output logic                      rxReady,
	input  wire logic                 rxFromBle,
	input  wire logic [1:0]           rxSource,
	output logic [7:0]                txData,
	output logic                      txValid,
	input  wire logic                 txReady,
	input  wire logic                 serialApiMode,
	input  wire logic                 bleConnected,
	input  wire logic                 scriptReady,
	input  wire logic [31:0]          saltValue,
	input  wire logic                 cryptoErr,
	input  wire logic                 proofOk,
	input  wire logic [7:0]           ckData,
	input  wire logic                 ckValid,
	output logic                      ckReady,
	output aurf_pkg::aurf_peer_t      peerOut,
	output logic                      peerValid,
	output logic                      linkDrop,
	output logic                      unlocked,
	output aurf_pkg::aurf_ctrblk_t    inboundCtr,
	output aurf_pkg::aurf_ctrblk_t    outboundCtr,
	output aurf_pkg::aurf_relay_t     relayOut,
	output logic                      relayValid,
	input  wire logic                 relayReady
);
	import aurf_pkg::*;

	typedef struct packed {
		aurf_rx_t    rxSt;
		logic [15:0] rxLen;
		logic [15:0] rxIdx;
		logic [7:0]  rxSum;
		logic [7:0]  rxType;
		logic [7:0]  rxId;
		logic [7:0]  rxDest;
		logic        aNonZero;
		logic        ovf;
		logic        awaitM1;
		logic        unlocked;
		logic        linkDrop;
		aurf_peer_t  peer;
		logic        peerValid;
		logic        txRun;
		aurf_kind_t  txKind;
		logic [15:0] txIdx;
		logic [15:0] txLen;
		logic [7:0]  txId;
		logic [7:0]  txCode;
		logic [7:0]  txSum;
		logic [7:0]  outData;
		logic        outValid;
		logic [95:0] txNonce;
		logic [95:0] rxNonce;
		logic        drainOn;
		logic [1:0]  drainDest;
		logic [15:0] drainCnt;
		aurf_relay_t relay;
		logic        relayValid;
	} aurf_state_t;

	aurf_state_t s;
	aurf_state_t next_s;

	logic        flushFifo;
	logic        pushValid;
	logic        popReady;
	logic        fifoInReady;
	logic [7:0]  fifoData;
	logic        fifoValid;
	logic        gated;
	logic        goodCks;
	logic        destReady;
	logic        launch;
	aurf_kind_t  lKind;
	logic [15:0] lLen;
	logic [7:0]  lId;
	logic [7:0]  lCode;
	logic [15:0] bodyEnd;
	logic [7:0]  txByte;
	logic        txAvail;
	logic [1:0]  saltSel;

	// True when idx lies in [lo, lo + n).
	function automatic logic inRange(input logic [15:0] idx, input logic [15:0] lo,
	                                 input logic [15:0] n);
		inRange = (idx >= lo) && (idx < 16'(lo + n));
	endfunction : inRange

	// Relay payloads wait here until the checksum has been seen.
	aurf_fifo #(
		.WIDTH    (8),
		.DEPTH    (FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.srst     (srst),
		.flush    (flushFifo),
		.inData   (rxData),
		.inValid  (pushValid),
		.inReady  (fifoInReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (popReady)
	);

	// Port drive; the receiver stalls while an answer or a drain is running.
	assign rxReady     = !s.txRun && !s.drainOn;
	assign txData      = s.outData;
	assign txValid     = s.outValid;
	assign peerOut     = s.peer;
	assign peerValid   = s.peerValid;
	assign linkDrop    = s.linkDrop;
	assign unlocked    = s.unlocked;
	assign relayOut    = s.relay;
	assign relayValid  = s.relayValid;
	assign inboundCtr  = '{nonce: s.txNonce, count: AURF_CTR_INIT};
	assign outboundCtr = '{nonce: s.rxNonce, count: AURF_CTR_INIT};

	// Frame parsing, decisions, answer generation and relay draining.
	always_comb begin
		next_s    = s;
		flushFifo = 1'b0;
		pushValid = 1'b0;
		popReady  = 1'b0;
		ckReady   = 1'b0;
		launch    = 1'b0;
		lKind     = AURF_K_STATUS;
		lLen      = AURF_LEN_STATUS;
		lId       = s.rxId;
		lCode     = AURF_ZERO_BYTE;
		txByte    = AURF_ZERO_BYTE;
		txAvail   = 1'b0;
		saltSel   = 2'(s.txIdx - AURF_OFS_PAYLOAD);
		bodyEnd   = 16'(AURF_OFS_TYPE + s.txLen);
		gated     = !rxFromBle || s.unlocked;
		goodCks   = (8'(s.rxSum + rxData) == AURF_CKS_BASE);
		unique case (s.rxDest)
			AURF_DEST_SERIAL: destReady = serialApiMode;
			AURF_DEST_BLE:    destReady = bleConnected;
			default:          destReady = scriptReady;
		endcase
		next_s.peerValid = 1'b0;
		next_s.linkDrop  = 1'b0;

		// Receive side.
		if (rxValid && rxReady) begin
			unique case (s.rxSt)
				AURF_RX_IDLE: begin
					if (rxData == AURF_DELIM) begin
						next_s.rxSt     = AURF_RX_LEN_HI;
						next_s.rxSum    = AURF_ZERO_BYTE;
						next_s.aNonZero = 1'b0;
						next_s.ovf      = 1'b0;
					end
				end
				AURF_RX_LEN_HI: begin
					next_s.rxLen[15:8] = rxData;
					next_s.rxSt        = AURF_RX_LEN_LO;
				end
				AURF_RX_LEN_LO: begin
					next_s.rxLen[7:0] = rxData;
					next_s.rxIdx      = AURF_OFS_TYPE;
					next_s.rxSt       = ({s.rxLen[15:8], rxData} == '0) ? AURF_RX_IDLE
					                                                   : AURF_RX_BODY;
				end
				AURF_RX_BODY: begin
					next_s.rxSum = 8'(s.rxSum + rxData);
					if (s.rxIdx == AURF_OFS_TYPE) next_s.rxType = rxData;
					if (s.rxIdx == AURF_OFS_ID) next_s.rxId = rxData;
					if (s.rxIdx == AURF_OFS_DEST) next_s.rxDest = rxData;
					// Client key and proof bytes go to the crypto engine.
					if (s.rxType == AURF_TYPE_UNLK_REQ && s.rxIdx >= AURF_OFS_PAYLOAD) begin
						next_s.peer      = '{data: rxData, step: s.rxId};
						next_s.peerValid = 1'b1;
						if (rxData != AURF_ZERO_BYTE) next_s.aNonZero = 1'b1;
					end
					// Relay payload is queued; an overrun sets ovf so the frame gets a busy status.
					if (s.rxType == AURF_TYPE_RELAY_IN && gated &&
					    s.rxIdx >= AURF_OFS_RELAY_DATA) begin
						pushValid = 1'b1;
						if (!fifoInReady) next_s.ovf = 1'b1;
					end
					next_s.rxIdx = 16'(s.rxIdx + AURF_ONE);
					if (s.rxIdx == 16'(AURF_OFS_TYPE + s.rxLen - AURF_ONE)) begin
						next_s.rxSt = AURF_RX_CKS;
					end
				end
				AURF_RX_CKS: begin
					next_s.rxSt = AURF_RX_IDLE;
					flushFifo   = 1'b1;
					if (!goodCks) begin
						flushFifo = 1'b1;
					end else if (s.rxType == AURF_TYPE_UNLK_REQ) begin
						launch = 1'b1;
						lKind  = AURF_K_UNLOCK;
						lLen   = AURF_LEN_RSP_ERR;
						if (s.rxId == AURF_STEP_A && !s.unlocked) begin
							next_s.awaitM1 = 1'b0;
							if (s.rxLen != AURF_LEN_STEP_A) begin
								lId = AURF_ERR_LENGTH;
							end else if (!s.aNonZero) begin
								launch          = 1'b0;
								next_s.linkDrop = 1'b1;
							end else if (cryptoErr) begin
								lId = AURF_ERR_CRYPTO;
							end else begin
								lId            = AURF_STEP_B;
								lLen           = AURF_LEN_RSP_B;
								next_s.awaitM1 = 1'b1;
							end
						end else if (s.rxId == AURF_STEP_M1 && s.awaitM1) begin
							next_s.awaitM1 = 1'b0;
							if (s.rxLen != AURF_LEN_STEP_M1) begin
								lId = AURF_ERR_LENGTH;
							end else if (!proofOk) begin
								lId = AURF_ERR_PROOF;
							end else begin
								lId  = AURF_STEP_M2;
								lLen = AURF_LEN_RSP_M2;
							end
						end else begin
							next_s.awaitM1 = 1'b0;
							lId            = AURF_ERR_SEQUENCE;
						end
					end else if (s.rxType == AURF_TYPE_RELAY_IN && gated) begin
						if (s.rxDest > AURF_DEST_SCRIPT) begin
							launch = (s.rxId != AURF_ZERO_BYTE);
							lCode  = AURF_ST_BAD_IFACE;
						end else if (s.ovf || !destReady) begin
							launch = (s.rxId != AURF_ZERO_BYTE);
							lCode  = AURF_ST_BUSY;
						end else if (s.rxDest == AURF_DEST_SERIAL) begin
							flushFifo = 1'b0;
							launch    = 1'b1;
							lKind     = AURF_K_RELAY;
							lLen      = 16'(s.rxLen - AURF_LEN_OUT_ADJ);
							lId       = {6'h00, rxSource};
						end else begin
							flushFifo        = 1'b0;
							next_s.drainDest = s.rxDest[1:0];
							next_s.drainCnt  = 16'(s.rxLen - AURF_LEN_RELAY_HDR);
							next_s.drainOn   = (s.rxLen != AURF_LEN_RELAY_HDR);
						end
					end
				end
				default: begin
					next_s.rxSt = AURF_RX_IDLE;
				end
			endcase
		end

		// Start of an answer frame.
		if (launch) begin
			next_s.txRun  = 1'b1;
			next_s.txKind = lKind;
			next_s.txIdx  = AURF_OFS_DELIM;
			next_s.txLen  = lLen;
			next_s.txId   = lId;
			next_s.txCode = lCode;
			next_s.txSum  = AURF_ZERO_BYTE;
		end

		// Output byte register empties when the sink takes it.
		if (s.outValid && txReady) next_s.outValid = 1'b0;

		// Transmit side: one byte per cycle when the output register is free.
		if (s.txRun && (!s.outValid || txReady)) begin
			txAvail = 1'b1;
			if (s.txIdx == AURF_OFS_DELIM) begin
				txByte = AURF_DELIM;
			end else if (s.txIdx == AURF_OFS_LEN_HI) begin
				txByte = s.txLen[15:8];
			end else if (s.txIdx == AURF_OFS_LEN_LO) begin
				txByte = s.txLen[7:0];
			end else if (s.txIdx == bodyEnd) begin
				txByte = 8'(AURF_CKS_BASE - s.txSum);
			end else if (s.txIdx == AURF_OFS_TYPE) begin
				unique case (s.txKind)
					AURF_K_STATUS: txByte = AURF_TYPE_TX_STATUS;
					AURF_K_UNLOCK: txByte = AURF_TYPE_UNLK_RSP;
					AURF_K_RELAY:  txByte = AURF_TYPE_RELAY_OUT;
					default:       txByte = AURF_ZERO_BYTE;
				endcase
			end else if (s.txIdx == AURF_OFS_ID) begin
				txByte = s.txId;
			end else if (s.txKind == AURF_K_STATUS) begin
				txByte = s.txCode;
			end else if (s.txKind == AURF_K_RELAY) begin
				txByte   = fifoData;
				txAvail  = fifoValid;
				popReady = fifoValid;
			end else if (s.txId == AURF_STEP_B && s.txIdx < AURF_OFS_B) begin
				txByte = 8'(saltValue >> {~saltSel, 3'b000});
			end else begin
				txByte  = ckData;
				txAvail = ckValid;
				ckReady = ckValid;
			end
			if (txAvail) begin
				next_s.outData  = txByte;
				next_s.outValid = 1'b1;
				next_s.txIdx    = 16'(s.txIdx + AURF_ONE);
				if (s.txIdx >= AURF_OFS_TYPE && s.txIdx < bodyEnd) begin
					next_s.txSum = 8'(s.txSum + txByte);
				end
				// Nonces are kept as they leave in the M2 answer.
				if (s.txKind == AURF_K_UNLOCK && s.txId == AURF_STEP_M2) begin
					if (inRange(s.txIdx, AURF_OFS_TX_NONCE, AURF_NONCE_BYTES)) begin
						next_s.txNonce = {s.txNonce[87:0], txByte};
					end
					if (inRange(s.txIdx, AURF_OFS_RX_NONCE, AURF_NONCE_BYTES)) begin
						next_s.rxNonce = {s.rxNonce[87:0], txByte};
					end
				end
				if (s.txIdx == bodyEnd) begin
					next_s.txRun = 1'b0;
					if (s.txKind == AURF_K_UNLOCK && s.txId == AURF_STEP_M2) begin
						next_s.unlocked = 1'b1;
					end
				end
			end
		end

		// Relay drain towards BLE or the scripting engine.
		if (s.relayValid && relayReady) next_s.relayValid = 1'b0;
		if (s.drainOn && fifoValid && (!s.relayValid || relayReady)) begin
			popReady          = 1'b1;
			next_s.relay      = '{data: fifoData, dest: s.drainDest,
			                      last: (s.drainCnt == AURF_ONE)};
			next_s.relayValid = 1'b1;
			next_s.drainCnt   = 16'(s.drainCnt - AURF_ONE);
			if (s.drainCnt == AURF_ONE) next_s.drainOn = 1'b0;
		end

		// Losing the link or a dropped client ends the session.
		if (!bleConnected || next_s.linkDrop) begin
			next_s.unlocked = 1'b0;
			next_s.awaitM1  = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule : aurf_framer
`default_nettype wire

// >>> verif/aurf_framer_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Port checker of the framer.
// ---------------------------------------------------------------------------
module aurf_framer_chk (
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	input  wire logic                   bleConnected,
	input  wire logic [7:0]             txData,
	input  wire logic                   txValid,
	input  wire logic                   txReady,
	input  wire logic                   linkDrop,
	input  wire logic                   unlocked,
	input  wire aurf_pkg::aurf_ctrblk_t inboundCtr,
	input  wire aurf_pkg::aurf_ctrblk_t outboundCtr,
	input  wire aurf_pkg::aurf_relay_t  relayOut,
	input  wire logic                   relayValid,
	input  wire logic                   relayReady
);
	import aurf_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// A stalled output keeps its byte until the far side takes it.
	sequence s_txWait;
		txValid && !txReady;
	endsequence
	sequence s_relayWait;
		relayValid && !relayReady;
	endsequence
	tx_hold_a: assert property (s_txWait |=> txValid && $stable(txData))
		else $error("answer byte not held");
	relay_hold_a: assert property (s_relayWait |=> relayValid && $stable(relayOut))
		else $error("relay byte not held");
	frame_start_a: assert property ($rose(txValid) |-> txData == AURF_DELIM)
		else $error("frame lacks delimiter");
	drop_pulse_a: assert property (linkDrop |=> !linkDrop)
		else $error("link drop too long");
	ctr_count_a: assert property (unlocked |-> inboundCtr.count == AURF_CTR_INIT
		&& outboundCtr.count == AURF_CTR_INIT) else $error("counter not at one");
	ble_clear_a: assert property (!bleConnected |=> !unlocked)
		else $error("unlock outlived link");
	relay_dest_a: assert property (relayValid |-> relayOut.dest inside {2'h1, 2'h2})
		else $error("bad relay destination");
	reset_clear_a: assert property (disable iff (1'b0) srst |=> !txValid && !unlocked
		&& !linkDrop && !relayValid) else $error("reset left outputs set");
endmodule : aurf_framer_chk
bind aurf_framer aurf_framer_chk i_aurf_framer_chk (
	.core_clk(core_clk), .srst(srst), .bleConnected(bleConnected), .txData(txData),
	.txValid(txValid), .txReady(txReady), .linkDrop(linkDrop), .unlocked(unlocked),
	.inboundCtr(inboundCtr), .outboundCtr(outboundCtr), .relayOut(relayOut),
	.relayValid(relayValid), .relayReady(relayReady)
);
`default_nettype wire

// >>> verif/aurf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Far side: answer sink, relay sink and crypto byte source.
// ---------------------------------------------------------------------------
module aurf_host_model #(
	parameter logic [7:0] CK_FIRST = 8'h5A
) (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic [7:0]            txData,
	input  wire logic                  txValid,
	output logic                       txReady,
	output logic [7:0]                 ckData,
	output logic                       ckValid,
	input  wire logic                  ckReady,
	input  wire aurf_pkg::aurf_relay_t relayOut,
	input  wire logic                  relayValid,
	output logic                       relayReady,
	input  wire logic                  linkDrop
);
	import aurf_pkg::*;
	logic [7:0]  got[$];
	aurf_relay_t rgot[$];
	int          drops;
	assign ckValid = 1'b1;
	// Both sinks stall every other cycle; each taken byte is recorded.
	always @(posedge core_clk) begin
		if (srst) begin
			txReady <= 1'b0;
			relayReady <= 1'b0;
			ckData <= CK_FIRST;
			drops <= 0;
		end else begin
			txReady <= !txReady;
			relayReady <= !relayReady;
			if (txValid && txReady) got.push_back(txData);
			if (relayValid && relayReady) rgot.push_back(relayOut);
			if (ckReady) ckData <= ckData + 8'h01;
			if (linkDrop) drops <= drops + 1;
		end
	end
endmodule : aurf_host_model
`default_nettype wire

// >>> verif/api_unlock_and_user_relay_frames_test.sv
`timescale 1ns/10ps
`default_nettype none
module api_unlock_and_user_relay_frames_test;
	import aurf_pkg::*;
	localparam logic [7:0] CK_FIRST = 8'h5A;
	logic core_clk = 1'b0, srst = 1'b1, rxValid = 1'b0, serialApiMode = 1'b0, cryptoErr = 1'b0;
	logic bleConnected = 1'b1, scriptReady = 1'b0, proofOk = 1'b1, rxFromBle = 1'b0;
	logic [7:0] rxData = 8'h00, ck = CK_FIRST;
	logic [1:0] rxSource = 2'h0;
	logic [31:0] saltValue = 32'h1234_5678;
	logic rxReady, txValid, txReady, ckValid, ckReady, linkDrop, unlocked, relayValid, relayReady;
	logic [7:0] txData, ckData, q[$], e[$];
	logic [95:0] nin, nout;
	aurf_ctrblk_t inboundCtr, outboundCtr;
	aurf_relay_t relayOut;
	int checked = 0, miscompares = 0;
	always #4 core_clk = ~core_clk;
	aurf_framer #(.FIFO_DEPTH(8)) i_aurf_framer (.core_clk, .srst, .rxData, .rxValid, .rxReady,
		.rxFromBle, .rxSource, .txData, .txValid, .txReady, .serialApiMode, .bleConnected,
		.scriptReady, .saltValue, .cryptoErr, .proofOk, .ckData, .ckValid, .ckReady,
		.peerOut(), .peerValid(), .linkDrop, .unlocked, .inboundCtr, .outboundCtr, .relayOut,
		.relayValid, .relayReady);
	aurf_host_model #(.CK_FIRST(CK_FIRST)) i_aurf_host_model (.core_clk, .srst, .txData, .txValid,
		.txReady, .ckData, .ckValid, .ckReady, .relayOut, .relayValid, .relayReady, .linkDrop);
	// ------------------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------------------
	task automatic close_out();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic chk(input logic [127:0] seen, input logic [127:0] want);
		checked++;
		if (seen !== want) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : chk
	task automatic put(input logic [7:0] b);
		int n;
		n = 0;
		rxData <= b;
		rxValid <= 1'b1;
		@(negedge core_clk);
		while (!rxReady && n < 1000) begin
			@(negedge core_clk);
			n++;
		end
		if (n == 1000) begin
			miscompares++;
			close_out();
		end
		@(posedge core_clk);
	endtask : put
	// Sends the body in q framed with length and checksum, corrupted on request.
	task automatic send(input logic bad);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[i]) s += q[i];
		put(AURF_DELIM);
		put(8'h00);
		put(8'(q.size()));
		foreach (q[i]) put(q[i]);
		put((AURF_CKS_BASE - s) ^ {7'h00, bad});
		rxValid <= 1'b0;
		q.delete();
	endtask : send
	// Waits for the frame whose body is in e, or for silence if e is empty.
	task automatic settle();
		logic [7:0] x[$];
		logic [7:0] s;
		int n;
		s = 8'h00;
		n = 0;
		foreach (e[i]) s += e[i];
		if (e.size() > 0) x = {AURF_DELIM, 8'h00, 8'(e.size()), e, AURF_CKS_BASE - s};
		while (i_aurf_host_model.got.size() < x.size() && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 2000) begin
			miscompares++;
			close_out();
		end
		repeat (20) @(posedge core_clk);
		chk(i_aurf_host_model.got.size(), x.size());
		foreach (x[i]) chk(i_aurf_host_model.got[i], x[i]);
		i_aurf_host_model.got.delete();
		e.delete();
	endtask : settle
	// ------------------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------------------
	task automatic sc_status();
		q = {AURF_TYPE_RELAY_IN, 8'h11, 8'h03, 8'hC4};
		send(1'b0);
		e = {AURF_TYPE_TX_STATUS, 8'h11, AURF_ST_BAD_IFACE};
		settle();
		q = {AURF_TYPE_RELAY_IN, 8'h12, AURF_DEST_SERIAL, 8'hC5};
		send(1'b0);
		e = {AURF_TYPE_TX_STATUS, 8'h12, AURF_ST_BUSY};
		settle();
		q = {AURF_TYPE_RELAY_IN, 8'h00, 8'h03, 8'hC6};
		send(1'b0);
		settle();
	endtask : sc_status
	task automatic sc_relay();
		serialApiMode <= 1'b1;
		scriptReady <= 1'b1;
		rxSource <= 2'h2;
		q = {AURF_TYPE_RELAY_IN, 8'h21, AURF_DEST_SERIAL, 8'hA1, 8'hA2};
		send(1'b0);
		e = {AURF_TYPE_RELAY_OUT, 8'h02, 8'hA1, 8'hA2};
		settle();
		q = {AURF_TYPE_RELAY_IN, 8'h22, AURF_DEST_SERIAL, 8'hA3};
		send(1'b1);
		settle();
		q = {AURF_TYPE_RELAY_IN, 8'h31, AURF_DEST_SCRIPT, 8'hB1, 8'hB2, 8'hB3};
		send(1'b0);
		settle();
		chk(i_aurf_host_model.rgot.size(), 3);
		foreach (i_aurf_host_model.rgot[i])
			chk(i_aurf_host_model.rgot[i], {8'(8'hB1 + i), 2'h2, 1'(i == 2)});
	endtask : sc_relay
	task automatic sc_unlock();
		q = {AURF_TYPE_UNLK_REQ, AURF_STEP_A};
		repeat (128) q.push_back(8'h33);
		send(1'b0);
		// The salt bytes are the bench's salt value, most significant first.
		e = {AURF_TYPE_UNLK_RSP, AURF_STEP_B, 8'h12, 8'h34, 8'h56, 8'h78};
		repeat (128) e.push_back(ck++);
		settle();
		q = {AURF_TYPE_UNLK_REQ, AURF_STEP_M1};
		repeat (32) q.push_back(8'h44);
		send(1'b0);
		e = {AURF_TYPE_UNLK_RSP, AURF_STEP_M2};
		for (int i = 0; i < 56; i++) begin
			if (i >= 32 && i < 44) nin = {nin[87:0], ck};
			if (i >= 44) nout = {nout[87:0], ck};
			e.push_back(ck++);
		end
		settle();
		chk(unlocked, 1'b1);
		chk(inboundCtr, {nin, AURF_CTR_INIT});
		chk(outboundCtr, {nout, AURF_CTR_INIT});
		q = {AURF_TYPE_UNLK_REQ, AURF_STEP_M1, 8'h44};
		send(1'b0);
		e = {AURF_TYPE_UNLK_RSP, AURF_ERR_SEQUENCE};
		settle();
	endtask : sc_unlock
	task automatic sc_drop();
		bleConnected <= 1'b0;
		@(posedge core_clk);
		bleConnected <= 1'b1;
		@(posedge core_clk);
		chk(unlocked, 1'b0);
		rxFromBle <= 1'b1;
		q = {AURF_TYPE_RELAY_IN, 8'h41, 8'h03, 8'hC7};
		send(1'b0);
		settle();
		q = {AURF_TYPE_UNLK_REQ, AURF_STEP_A};
		repeat (128) q.push_back(AURF_ZERO_BYTE);
		send(1'b0);
		settle();
		chk(i_aurf_host_model.drops, 1);
		cryptoErr <= 1'b1;
		q = {AURF_TYPE_UNLK_REQ, AURF_STEP_A};
		repeat (128) q.push_back(8'h33);
		send(1'b0);
		e = {AURF_TYPE_UNLK_RSP, AURF_ERR_CRYPTO};
		settle();
	endtask : sc_drop
	// Reset for two cycles, then the scenarios in turn.
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		sc_status();
		sc_relay();
		sc_unlock();
		sc_drop();
		close_out();
	end
endmodule : api_unlock_and_user_relay_frames_test
`default_nettype wire
